// ### rtl/flash_cmd_decoder.sv
`timescale 1ns/100ps
`include "flash_cmd_params.svh"
module flash_cmd_decoder
  import flash_cmd_pkg::*;
#(
  parameter int TIMEOUT_CYC = `BYTE_TIMEOUT_CYC,
  parameter int WINDOW_CYC = `WINDOW_CYC,
  parameter int ERASE_CYC = `SECTOR_ERASE_CYC,
  parameter logic [7:0] IDENT_CODE = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Host bus
  flash_bus_if.device bus,
  // Array side
  input wire logic [7:0] array_rdata,
  input wire logic [7:0] protect_map,
  input wire logic fail_in,
  output logic op_start,
  output logic [1:0] op_kind,
  output logic op_secondary,
  output logic [15:0] op_addr,
  output logic [7:0] op_data,
  output logic busy
);
  if (TIMEOUT_CYC < 2 || WINDOW_CYC < 2 || ERASE_CYC < 2) begin : g_bad_cnt
    $error("counts too small");
  end
  dec_state_t st_r, st_nxt;
  logic bypass_r, bypass_nxt, susp_r, susp_nxt, tog_r, tog_nxt;
  logic byp2_r, byp2_nxt, bex_r, bex_nxt, sec_r, sec_nxt;
  logic win_r, win_nxt, fail_r, fail_nxt, start_r, start_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic [15:0] oa_r, oa_nxt;
  logic [7:0] od_r, od_nxt, rd_r, rd_nxt, sector_r, sector_nxt;
  logic rv_r, rv_nxt;
  logic [31:0] gap_r, gap_nxt, run_r, run_nxt, win_cnt_r, win_cnt_nxt;
  logic [11:0] a;
  logic any_sel, in_erase_sector;
  assign a = bus.addr[11:0];
  assign any_sel = |bus.primary_sector_selects
    | |bus.secondary_sector_selects;
  assign in_erase_sector = |(bus.primary_sector_selects & sector_r);

  always_comb begin
    st_nxt = st_r;
    bypass_nxt = bypass_r;
    susp_nxt = susp_r;
    tog_nxt = tog_r;
    byp2_nxt = byp2_r;
    bex_nxt = bex_r;
    sec_nxt = sec_r;
    win_nxt = win_r;
    fail_nxt = fail_r;
    start_nxt = 1'b0;
    kind_nxt = kind_r;
    oa_nxt = oa_r;
    od_nxt = od_r;
    rd_nxt = rd_r;
    rv_nxt = 1'b0;
    sector_nxt = sector_r;
    gap_nxt = gap_r;
    run_nxt = run_r;
    win_cnt_nxt = win_cnt_r;
    // Inter-byte time-out only runs mid-sequence
    if (st_r == ST_CODE1 || st_r == ST_CODE2 || st_r == ST_PROG_DATA
        || st_r == ST_ESETUP || byp2_r || bex_r) begin
      if (gap_r >= 32'(TIMEOUT_CYC - 1)) begin
        st_nxt = ST_READ;
        byp2_nxt = 1'b0;
        bex_nxt = 1'b0;
        gap_nxt = '0;
      end else begin
        gap_nxt = gap_r + 32'd1;
      end
    end
    // Embedded algorithm model: waits, multi-sector window, run
    if (st_r == ST_BUSY && !susp_r) begin
      if (kind_r == OP_SECTOR && !win_r) begin
        if (win_cnt_r >= 32'(WINDOW_CYC - 1)) begin
          win_nxt = 1'b1;
        end else begin
          win_cnt_nxt = win_cnt_r + 32'd1;
        end
      end else if (fail_in) begin
        st_nxt = ST_FAIL;
        fail_nxt = 1'b1;
      end else if (run_r >= 32'(ERASE_CYC - 1)
          || (kind_r == OP_PROGRAM && run_r >= 32'(`PROGRAM_CYC - 1)))
      begin
        st_nxt = bypass_r ? ST_READ : ST_READ;
        run_nxt = '0;
      end else begin
        run_nxt = run_r + 32'd1;
      end
    end
    if (bus.rd_stb && any_sel) begin
      rv_nxt = 1'b1;
      if ((st_r == ST_BUSY && !(susp_r && !in_erase_sector))
          || st_r == ST_FAIL) begin
        rd_nxt = 8'h00;
        rd_nxt[`POLL_BIT] = (kind_r == OP_PROGRAM) ? ~od_r[7]
          : 1'b0;
        rd_nxt[`TOGGLE_BIT] = tog_r;
        rd_nxt[`FAIL_BIT] = fail_r;
        rd_nxt[`WINDOW_BIT] = win_r;
        tog_nxt = ~tog_r;
      end else if (st_r == ST_ID_MODE) begin
        if (bus.addr[1:0] == `IDENT_ADDR_LOW && !sec_r)
          rd_nxt = IDENT_CODE;
        else if (bus.addr[1:0] == `PROTECT_ADDR_LOW)
          rd_nxt = {7'h00, |(protect_map
            & bus.primary_sector_selects)};
        else
          rd_nxt = array_rdata;
      end else begin
        rd_nxt = array_rdata;
      end
    end
    if (bus.wr_stb && any_sel) begin
      gap_nxt = '0;
      if (bus.wdata == `CMD_RESET && !bypass_r) begin
        st_nxt = (st_r == ST_BUSY) ? ST_BUSY : ST_READ;
        fail_nxt = 1'b0;
        if (st_r == ST_FAIL) st_nxt = ST_READ;
      end else if (st_r == ST_BUSY && kind_r == OP_SECTOR) begin
        if (bus.wdata == `CMD_SUSPEND && !susp_r) begin
          susp_nxt = 1'b1;
        end else if (bus.wdata == `CMD_RESUME && susp_r) begin
          susp_nxt = 1'b0;
        end else if (bus.wdata == `CMD_SECTOR_ERASE && !win_r) begin
          sector_nxt = sector_r | bus.primary_sector_selects;
          win_cnt_nxt = '0;
        end
      end else if (bypass_r) begin
        if (byp2_r) begin
          byp2_nxt = 1'b0;
          oa_nxt = bus.addr;
          od_nxt = bus.wdata;
          kind_nxt = OP_PROGRAM;
          start_nxt = 1'b1;
          run_nxt = '0;
          st_nxt = ST_BUSY;
        end else if (bex_r) begin
          bex_nxt = 1'b0;
          if (bus.wdata == `CMD_BYPASS_EXIT)
            bypass_nxt = 1'b0;
        end else if (bus.wdata == `CMD_PROGRAM) begin
          byp2_nxt = 1'b1;
        end else if (bus.wdata == `CMD_IDENT) begin
          bex_nxt = 1'b1;
        end
      end else begin
        case (st_r)
          ST_READ, ST_ID_MODE: begin
            if (st_r == ST_ID_MODE && susp_r) st_nxt = ST_ID_MODE;
            if (bus.wdata == `BYTE_CODE1 && a == `ADDR_CODE1) begin
              st_nxt = ST_CODE1;
              sec_nxt = ~|bus.primary_sector_selects;
            end else if (st_r == ST_READ) begin
              st_nxt = ST_READ;
            end
          end
          ST_CODE1: begin
            st_nxt = (bus.wdata == `BYTE_CODE2 && a == `ADDR_CODE2)
              ? ST_CODE2 : ST_READ;
          end
          ST_CODE2: begin
            st_nxt = ST_READ;
            if (a == `ADDR_CODE1) begin
              case (bus.wdata)
                `CMD_PROGRAM: st_nxt = ST_PROG_DATA;
                `CMD_ERASE_SETUP: st_nxt = susp_r ? ST_READ : ST_ESETUP;
                `CMD_IDENT: st_nxt = ST_ID_MODE;
                `CMD_BYPASS: bypass_nxt = 1'b1;
                default: st_nxt = ST_READ;
              endcase
            end
            if (kind_r == OP_SECTOR && susp_r
                && bus.wdata == `CMD_ERASE_SETUP) st_nxt = ST_READ;
          end
          ST_PROG_DATA: begin
            oa_nxt = bus.addr;
            od_nxt = bus.wdata;
            start_nxt = 1'b1;
            run_nxt = '0;
            st_nxt = ST_BUSY;
            if (!susp_r) kind_nxt = OP_PROGRAM;
          end
          ST_ESETUP: begin
            // Second coded pair is folded into the setup check
            st_nxt = ST_READ;
            if (bus.wdata == `CMD_SECTOR_ERASE) begin
              kind_nxt = OP_SECTOR;
              sector_nxt = bus.primary_sector_selects;
              win_nxt = 1'b0;
              win_cnt_nxt = '0;
              run_nxt = '0;
              start_nxt = 1'b1;
              oa_nxt = bus.addr;
              st_nxt = ST_BUSY;
            end else if (bus.wdata == `CMD_BULK_ERASE
                && a == `ADDR_CODE1) begin
              kind_nxt = OP_BULK;
              run_nxt = '0;
              start_nxt = 1'b1;
              oa_nxt = bus.addr;
              st_nxt = ST_BUSY;
            end else if (bus.wdata == `BYTE_CODE1
                || bus.wdata == `BYTE_CODE2) begin
              st_nxt = ST_ESETUP;
            end
          end
          ST_FAIL: st_nxt = ST_FAIL;
          // Stray writes must not cut a running program short
          ST_BUSY: st_nxt = ST_BUSY;
          default: st_nxt = ST_READ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_READ;
      bypass_r <= 1'b0;
      susp_r <= 1'b0;
      tog_r <= 1'b0;
      byp2_r <= 1'b0;
      bex_r <= 1'b0;
      sec_r <= 1'b0;
      win_r <= 1'b0;
      fail_r <= 1'b0;
      start_r <= 1'b0;
      kind_r <= OP_NONE;
      oa_r <= 16'h0000;
      od_r <= 8'h00;
      rd_r <= 8'h00;
      rv_r <= 1'b0;
      sector_r <= 8'h00;
      gap_r <= '0;
      run_r <= '0;
      win_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      bypass_r <= bypass_nxt;
      susp_r <= susp_nxt;
      tog_r <= tog_nxt;
      byp2_r <= byp2_nxt;
      bex_r <= bex_nxt;
      sec_r <= sec_nxt;
      win_r <= win_nxt;
      fail_r <= fail_nxt;
      start_r <= start_nxt;
      kind_r <= kind_nxt;
      oa_r <= oa_nxt;
      od_r <= od_nxt;
      rd_r <= rd_nxt;
      rv_r <= rv_nxt;
      sector_r <= sector_nxt;
      gap_r <= gap_nxt;
      run_r <= run_nxt;
      win_cnt_r <= win_cnt_nxt;
    end
  end

  assign bus.rdata = rd_r;
  assign bus.rvalid = rv_r;
  assign op_start = start_r;
  assign op_kind = kind_r;
  assign op_secondary = sec_r;
  assign op_addr = oa_r;
  assign op_data = od_r;
  assign busy = st_r[6];
endmodule : flash_cmd_decoder

// ### rtl/flash_cmd_params.svh
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH
`define ADDR_CODE1 12'h555
`define ADDR_CODE2 12'hAAA
`define BYTE_CODE1 8'hAA
`define BYTE_CODE2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_BULK_ERASE 8'h10
`define CMD_IDENT 8'h90
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30
`define CMD_RESET 8'hF0
`define CMD_BYPASS 8'h20
`define CMD_BYPASS_EXIT 8'h00
`define IDENT_ADDR_LOW 2'h1
`define PROTECT_ADDR_LOW 2'h2
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define FAIL_BIT 5
`define WINDOW_BIT 3
`define CLK_MHZ 40
`define BYTE_TIMEOUT_US 80
`define BYTE_TIMEOUT_CYC (`BYTE_TIMEOUT_US * `CLK_MHZ)
`define WINDOW_US 100
`define WINDOW_CYC (`WINDOW_US * `CLK_MHZ)
`define PROGRAM_CYC 64
`define SECTOR_ERASE_CYC 4096
`endif

// ### rtl/flash_cmd_pkg.sv
package flash_cmd_pkg;
  typedef enum logic [7:0] {
    ST_READ = 8'h01,
    ST_CODE1 = 8'h02,
    ST_CODE2 = 8'h04,
    ST_PROG_DATA = 8'h08,
    ST_ESETUP = 8'h10,
    ST_ID_MODE = 8'h20,
    ST_BUSY = 8'h40,
    ST_FAIL = 8'h80
  } dec_state_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_PROGRAM = 2'h1,
    OP_SECTOR = 2'h2,
    OP_BULK = 2'h3
  } op_kind_t;
endpackage : flash_cmd_pkg

// ### rtl/flash_bus_if.sv
`timescale 1ns/100ps
interface flash_bus_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rd_stb;
  logic wr_stb;
  logic rvalid;
  logic [7:0] primary_sector_selects;
  logic [3:0] secondary_sector_selects;
  modport device (input addr, wdata, rd_stb, wr_stb,
    primary_sector_selects, secondary_sector_selects,
    output rdata, rvalid);
  modport host (output addr, wdata, rd_stb, wr_stb,
    primary_sector_selects, secondary_sector_selects,
    input rdata, rvalid);
endinterface : flash_bus_if

// ### rtl/flash_cmd_host.sv
`timescale 1ns/100ps
`include "flash_cmd_params.svh"
module flash_cmd_host
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // User request: one bus cycle each
  input wire logic req,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic req_secondary,
  input wire logic [2:0] req_sector,
  output logic ack,
  output logic [7:0] ack_rdata,
  // Device bus
  flash_bus_if.host bus
);
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] wd_r, wd_nxt, ps_r, ps_nxt, rdat_r, rdat_nxt;
  logic [3:0] ss_r, ss_nxt;
  logic rd_r, rd_nxt, wr_r, wr_nxt, ack_r, ack_nxt, wait_r, wait_nxt;
  logic rdp_r, rdp_nxt;

  always_comb begin
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    ps_nxt = ps_r;
    ss_nxt = ss_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    ack_nxt = 1'b0;
    wait_nxt = wait_r;
    rdat_nxt = rdat_r;
    rdp_nxt = rdp_r;
    if (req && !wait_r) begin
      rdp_nxt = ~req_write;
      addr_nxt = req_addr;
      wd_nxt = req_wdata;
      // Selects held for the whole cycle
      ps_nxt = req_secondary ? 8'h00 : (8'h01 << req_sector);
      ss_nxt = req_secondary ? (4'h1 << req_sector[1:0]) : 4'h0;
      rd_nxt = ~req_write;
      wr_nxt = req_write;
      wait_nxt = 1'b1;
    end else if (wait_r && !rd_r && !wr_r) begin
      // Writes and unselected reads get no answer, so finish at once
      if (bus.rvalid || !rdp_r || (ps_r == 8'h00 && ss_r == 4'h0)) begin
        rdp_nxt = 1'b0;
        wait_nxt = 1'b0;
        ack_nxt = 1'b1;
        rdat_nxt = bus.rdata;
        ps_nxt = 8'h00;
        ss_nxt = 4'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_r <= 16'h0000;
      wd_r <= 8'h00;
      ps_r <= 8'h00;
      ss_r <= 4'h0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      ack_r <= 1'b0;
      wait_r <= 1'b0;
      rdat_r <= 8'h00;
      rdp_r <= 1'b0;
    end else begin
      rdp_r <= rdp_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      ps_r <= ps_nxt;
      ss_r <= ss_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      ack_r <= ack_nxt;
      wait_r <= wait_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign bus.addr = addr_r;
  assign bus.wdata = wd_r;
  assign bus.rd_stb = rd_r;
  assign bus.wr_stb = wr_r;
  assign bus.primary_sector_selects = ps_r;
  assign bus.secondary_sector_selects = ss_r;
  assign ack = ack_r;
  assign ack_rdata = rdat_r;
endmodule : flash_cmd_host

// ### verification/flash_cmd_monitor.sv
`timescale 1ns/100ps
`include "flash_cmd_params.svh"
module flash_cmd_monitor #(
  parameter int TIMEOUT_CYC = 8,
  parameter logic [7:0] IDENT_CODE = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bus
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic rvalid,
  input wire logic [7:0] primary_sector_selects,
  input wire logic [3:0] secondary_sector_selects
);
  logic [19:0] h0_r, h1_r, h2_r;
  logic [1:0] ok_r;
  int gap_r;
  logic sel_p, sel_s, id_rdy;
  assign sel_p = |primary_sector_selects;
  assign sel_s = |secondary_sector_selects;
  // Last three writes; a margin of one cycle keeps clear of the time-out edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      h0_r <= 20'h0;
      h1_r <= 20'h0;
      h2_r <= 20'h0;
      ok_r <= 2'h0;
      gap_r <= TIMEOUT_CYC;
    end else if (wr_stb) begin
      h2_r <= h1_r;
      h1_r <= h0_r;
      h0_r <= {wdata, addr[11:0]};
      ok_r <= {ok_r[0], gap_r < TIMEOUT_CYC - 1};
      gap_r <= 0;
    end else if (gap_r < TIMEOUT_CYC) begin
      gap_r <= gap_r + 1;
    end
  end
  assign id_rdy = h2_r == {`BYTE_CODE1, `ADDR_CODE1} &&
    h1_r == {`BYTE_CODE2, `ADDR_CODE2} && h0_r == {`CMD_IDENT, `ADDR_CODE1}
    && (&ok_r) && gap_r < TIMEOUT_CYC - 1;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_id_rd;
    id_rdy && rd_stb && sel_p && addr[1:0] == `IDENT_ADDR_LOW;
  endsequence
  sequence s_pr_rd;
    id_rdy && rd_stb && sel_p && addr[1:0] == `PROTECT_ADDR_LOW;
  endsequence
  property p_ident;
    s_id_rd |=> rvalid && rdata == IDENT_CODE;
  endproperty
  property p_protect;
    s_pr_rd |=> rvalid && rdata[7:1] == 7'h00;
  endproperty
  property p_read;
    rd_stb && (sel_p || sel_s) |=> rvalid;
  endproperty
  property p_stray;
    rvalid |-> $past(rd_stb);
  endproperty
  property p_wr_sel;
    wr_stb |-> sel_p || sel_s;
  endproperty
  property p_spacing;
    rd_stb || wr_stb |=> !rd_stb && !wr_stb;
  endproperty
  property p_one_array;
    !(sel_p && sel_s);
  endproperty
  property p_power_up;
    $rose(rst_b) |-> !wr_stb && !sel_p && !sel_s;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identifier read gave a wrong byte");
  a_protect: assert property (p_protect)
    else $error("protection read not 00h or 01h");
  a_read: assert property (p_read)
    else $error("selected read got no answer");
  a_stray: assert property (p_stray)
    else $error("answer without a read");
  a_wr_sel: assert property (p_wr_sel)
    else $error("write without a sector select");
  a_spacing: assert property (p_spacing)
    else $error("strobes back to back");
  a_one_array: assert property (p_one_array)
    else $error("both arrays selected");
  a_power_up: assert property (p_power_up)
    else $error("bus not idle after reset");
endmodule : flash_cmd_monitor

// ### verification/dual_flash_command_decoder_tb.sv
`timescale 1ns/100ps
`include "flash_cmd_params.svh"
module dual_flash_command_decoder_tb;
  import flash_cmd_pkg::*;
  localparam int T_CYC = 8;
  localparam logic [7:0] ID = 8'h5A; // Arbitrary value
  localparam logic [7:0] ARR = 8'hC3;
  logic core_clk, rst_b, req, req_write, req_secondary, ack, fail_in;
  logic op_start, op_secondary, busy, cap_sec, a_sec;
  logic [2:0] req_sector, a_sect;
  logic [1:0] op_kind, cap_kind;
  logic [15:0] req_addr, op_addr;
  logic [7:0] req_wdata, ack_rdata, array_rdata, protect_map, op_data;
  logic [7:0] cap_data, st1, st2;
  int errors = 0;
  int n_tests = 0;
  int n_starts = 0;
  int base = 0;
  flash_bus_if flash_bus_if_i ();
  flash_cmd_decoder #(.TIMEOUT_CYC(T_CYC), .WINDOW_CYC(8), .ERASE_CYC(64),
    .IDENT_CODE(ID)) flash_cmd_decoder_i (.core_clk(core_clk),
    .rst_b(rst_b), .bus(flash_bus_if_i.device), .array_rdata(array_rdata),
    .protect_map(protect_map), .fail_in(fail_in), .op_start(op_start),
    .op_kind(op_kind), .op_secondary(op_secondary), .op_addr(op_addr),
    .op_data(op_data), .busy(busy));
  flash_cmd_host flash_cmd_host_i (.core_clk(core_clk), .rst_b(rst_b),
    .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_secondary(req_secondary),
    .req_sector(req_sector), .ack(ack), .ack_rdata(ack_rdata),
    .bus(flash_bus_if_i.host));
  flash_cmd_monitor #(.TIMEOUT_CYC(T_CYC), .IDENT_CODE(ID))
    flash_cmd_monitor_i (.core_clk(core_clk), .rst_b(rst_b),
    .addr(flash_bus_if_i.addr), .wdata(flash_bus_if_i.wdata),
    .rdata(flash_bus_if_i.rdata), .rd_stb(flash_bus_if_i.rd_stb),
    .wr_stb(flash_bus_if_i.wr_stb), .rvalid(flash_bus_if_i.rvalid),
    .primary_sector_selects(flash_bus_if_i.primary_sector_selects),
    .secondary_sector_selects(flash_bus_if_i.secondary_sector_selects));
  // Sampled mid-cycle so the one-cycle pulse is seen exactly once
  always @(negedge core_clk) begin
    if (op_start === 1'b1) begin
      n_starts++;
      cap_kind = op_kind;
      cap_sec = op_secondary;
      cap_data = op_data;
    end
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic access(input logic w, input logic [15:0] a,
      input logic [7:0] d, output logic [7:0] rd);
    int n;
    @(posedge core_clk);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_secondary <= a_sec;
    req_sector <= a_sect;
    @(posedge core_clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 8);
    check("ack", {7'h0, ack}, 8'h01);
    rd = ack_rdata;
  endtask : access
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] x;
    access(1'b1, a, d, x);
  endtask : wr
  task automatic rd_chk(input string what, input logic [15:0] a,
      input logic [7:0] exp);
    logic [7:0] x;
    access(1'b0, a, 8'h00, x);
    check(what, x, exp);
  endtask : rd_chk
  task automatic codes(input logic [7:0] cmd);
    wr(16'h7555, `BYTE_CODE1);
    wr(16'hBAAA, `BYTE_CODE2);
    wr(16'h3555, cmd);
  endtask : codes
  task automatic erase(input logic [15:0] a, input logic [7:0] cmd);
    codes(`CMD_ERASE_SETUP);
    wr(16'h0555, `BYTE_CODE1);
    wr(16'h0AAA, `BYTE_CODE2);
    wr(a, cmd);
  endtask : erase
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    check("idle", {7'h0, busy}, 8'h00);
  endtask : wait_idle
  task automatic status();
    access(1'b0, 16'h0100, 8'h00, st1);
    access(1'b0, 16'h0100, 8'h00, st2);
  endtask : status
  task automatic starts(input string what, input int k);
    check(what, 8'(n_starts - base), 8'(k));
    base = n_starts;
  endtask : starts
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    req_secondary = 1'b0;
    req_sector = 3'h0;
    array_rdata = ARR;
    protect_map = 8'h02;
    fail_in = 1'b0;
    a_sec = 1'b0;
    a_sect = 3'h0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk("array", 16'h1234, ARR);
    codes(`CMD_IDENT);
    rd_chk("ident", 16'h4001, ID);
    rd_chk("ident kept", 16'h4001, ID);
    wr(16'h0000, `CMD_RESET);
    rd_chk("reset", 16'h4001, ARR);
    for (int s = 0; s < 2; s++) begin
      a_sect = 3'(s);
      codes(`CMD_IDENT);
      rd_chk("protect", 16'h0002, {7'h0, protect_map[s]});
      wr(16'h0000, `CMD_RESET);
    end
    wr(16'h0555, `BYTE_CODE1);
    wr(16'h0AAA, 8'h12);
    rd_chk("bad byte", 16'h0010, ARR);
    wr(16'h0555, `BYTE_CODE1);
    repeat (3 * T_CYC) @(posedge core_clk);
    wr(16'h0AAA, `BYTE_CODE2);
    wr(16'h0555, `CMD_PROGRAM);
    wr(16'h0100, 8'h35);
    starts("timed out", 0);
    rd_chk("after time-out", 16'h0100, ARR);
    codes(`CMD_PROGRAM);
    wr(16'h0100, 8'h35);
    starts("program", 1);
    check("prog kind", {6'h0, cap_kind}, {6'h0, OP_PROGRAM});
    check("prog data", cap_data, 8'h35);
    status();
    check("poll", st1 & 8'h80, 8'h80);
    check("toggle", (st1 ^ st2) & 8'h40, 8'h40);
    check("no error", st1 & 8'h20, 8'h00);
    wait_idle();
    rd_chk("done", 16'h0100, ARR);
    a_sec = 1'b1;
    codes(`CMD_PROGRAM);
    wr(16'h0200, 8'hB5);
    starts("secondary", 1);
    check("route", {7'h0, cap_sec}, 8'h01);
    wait_idle();
    a_sec = 1'b0;
    erase(16'h0555, `CMD_BULK_ERASE);
    starts("bulk", 1);
    check("bulk kind", {6'h0, cap_kind}, {6'h0, OP_BULK});
    status();
    check("erase poll", st1 & 8'h80, 8'h00);
    wait_idle();
    a_sect = 3'h2;
    erase(16'h0000, `CMD_SECTOR_ERASE);
    starts("sector", 1);
    check("sect kind", {6'h0, cap_kind}, {6'h0, OP_SECTOR});
    repeat (12) @(posedge core_clk);
    status();
    check("window", st1 & 8'h08, 8'h08);
    wr(16'h0000, `CMD_SUSPEND);
    a_sect = 3'h5;
    rd_chk("suspended", 16'h0050, ARR);
    a_sect = 3'h2;
    wr(16'h0000, `CMD_RESUME);
    check("resumed", {7'h0, busy}, 8'h01);
    wait_idle();
    wr(16'h0000, `CMD_SUSPEND);
    wr(16'h0000, `CMD_RESUME);
    starts("idle suspend", 0);
    rd_chk("idle suspend", 16'h0000, ARR);
    codes(`CMD_BYPASS);
    for (int k = 0; k < 2; k++) begin
      wr(16'h0000, `CMD_PROGRAM);
      wr(16'h0300, 8'h11);
      starts("bypass", 1);
      check("bypass data", cap_data, 8'h11);
      wait_idle();
    end
    wr(16'h0000, `CMD_IDENT);
    wr(16'h0000, `CMD_BYPASS_EXIT);
    wr(16'h0000, `CMD_PROGRAM);
    wr(16'h0301, 8'h22);
    starts("bypass exit", 0);
    rd_chk("bypass exit", 16'h0301, ARR);
    codes(`CMD_PROGRAM);
    wr(16'h0100, 8'h00);
    @(posedge core_clk);
    fail_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    fail_in <= 1'b0;
    status();
    check("error", st1 & 8'h20, 8'h20);
    check("error kept", st2 & 8'h20, 8'h20);
    wr(16'h0000, `CMD_RESET);
    rd_chk("error reset", 16'h0100, ARR);
    end_of_test();
  end
endmodule : dual_flash_command_decoder_tb
